// ---- rtl/vih_pkg.sv ----
// Overview of operation
// - Twelve sources arbitrated across two priority levels.
// - Pending flag sets regardless of enable state.
// - Enabled pending source requests a vector call.
// - Return resumes the interrupted program flow.
// - Disabled pending flag produces no request.
// - Global enable bit gates every source enable.
// - Some flags cleared by hardware on vectoring.
// - Flag still set after return re-requests.
// - Software setting a flag acts as event.
// - External inputs select edge/level and polarity.
// - Edge external flag clears on vectoring.
// - Level external flag follows active input.
// - External inputs watch pins, crossbar undisturbed.
// - High priority preempts low, never preempted.
// - Higher level first, then fixed source order.
// - Sampled each cycle; fastest response five cycles.
// - One instruction runs after return before call.
// - Worst case response is eighteen cycles.
// - Equal or lower priority waits for return.
// - Vectors start at 0x0003, eight apart.
package vih_pkg;

  // ==========================================================================
  // Sizes and source order
  localparam int NUM_SRC = 12;
  localparam int SRC_W = 4;
  localparam int NUM_EXT = 2;
  localparam logic [SRC_W-1:0] SRC_EXT0 = 4'h0;
  localparam logic [SRC_W-1:0] SRC_EXT1 = 4'h2;

  // ==========================================================================
  // Field positions of the enable and priority inputs
  localparam int GLOBAL_EN_BIT = 7;
  localparam int BASE_FIELD_W = 6;
  localparam int EXT_FIELD_W = 6;

  // ==========================================================================
  // External input configuration codes
  localparam logic SENSE_EDGE = 1'b0;
  localparam logic SENSE_LEVEL = 1'b1;
  localparam logic POL_ACTIVE_LOW = 1'b0;
  localparam logic POL_ACTIVE_HIGH = 1'b1;

  // ==========================================================================
  // Sources whose flag hardware clears when the call is made
  localparam logic [NUM_SRC-1:0] HW_CLEAR_MASK = 12'h00f;

  // ==========================================================================
  // Vectors and timing counts, in system clock cycles
  localparam logic [15:0] RESET_VECTOR = 16'h0000;
  localparam logic [15:0] VECTOR_BASE = 16'h0003;
  localparam logic [15:0] VECTOR_STEP = 16'h0008;
  localparam int DETECT_CYCLES = 1;
  localparam int CALL_CYCLES = 4;
  localparam int RETURN_FROM_IRQ_CYCLES = 5;
  localparam int DIV_CYCLES = 8;
  localparam int MIN_RESPONSE_CYCLES = DETECT_CYCLES + CALL_CYCLES;
  localparam int MAX_RESPONSE_CYCLES = DETECT_CYCLES + RETURN_FROM_IRQ_CYCLES + DIV_CYCLES + CALL_CYCLES;
  localparam logic [2:0] CALL_CNT_LAST = 3'(CALL_CYCLES - 1);

  // ==========================================================================
  // Reset values
  localparam logic [NUM_SRC-1:0] FLAGS_RESET = 12'h000;
  localparam logic [1:0] IN_SERVICE_RESET = 2'h0;
  localparam logic EXT_PREV_RESET = 1'b1;

  // ==========================================================================
  // State types
  typedef enum logic [1:0] {
    ST_RUN = 2'b01,
    ST_CALL = 2'b10
  } vih_state_type;

  typedef struct packed {
    vih_state_type state;
    logic [NUM_SRC-1:0] flags;
    logic req_valid;
    logic req_high;
    logic [SRC_W-1:0] req_src;
    logic [2:0] call_cnt;
    logic [15:0] vector;
    logic [SRC_W-1:0] svc_src;
    logic [1:0] in_service;
  } vih_core_type;

  typedef struct packed {
    logic prev_active;
  } vih_ext_type;

endpackage : vih_pkg

// ---- rtl/vih_ext_sense.sv ----
`timescale 1ns/1ns
module vih_ext_sense (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic pin,
  input wire logic polarity,
  output logic active,
  output logic edge_event
);
  import vih_pkg::*;

  vih_ext_type state_reg;
  vih_ext_type state_next;

  // ==========================================================================
  // Polarity and edge detection
  always_comb begin
    active = (polarity == POL_ACTIVE_HIGH) ? pin : ~pin;
    edge_event = active & ~state_reg.prev_active;
    state_next = state_reg;
    state_next.prev_active = active;
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      state_reg.prev_active <= EXT_PREV_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

endmodule : vih_ext_sense

// ---- rtl/vih_irq_handler.sv ----
`timescale 1ns/1ns
module vih_irq_handler (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic ext_irq0_input,
  input wire logic ext_irq1_input,
  input wire logic ext0_sense_select,
  input wire logic ext1_sense_select,
  input wire logic ext0_polarity,
  input wire logic ext1_polarity,
  input wire logic [7:0] irq_enable_reg,
  input wire logic [vih_pkg::EXT_FIELD_W-1:0] irq_enable_ext_reg,
  input wire logic [7:0] irq_priority_reg,
  input wire logic [vih_pkg::EXT_FIELD_W-1:0] irq_priority_ext_reg,
  input wire logic [vih_pkg::NUM_SRC-1:0] periph_event,
  input wire logic [vih_pkg::NUM_SRC-1:0] sw_flag_set,
  input wire logic [vih_pkg::NUM_SRC-1:0] sw_flag_clr,
  input wire logic cpu_instr_done,
  input wire logic cpu_instr_is_return_from_irq,
  output logic [vih_pkg::NUM_SRC-1:0] pending_flags,
  output logic ext0_pending,
  output logic ext1_pending,
  output logic irq_request,
  output logic irq_request_high,
  output logic [vih_pkg::SRC_W-1:0] irq_request_src,
  output logic call_start,
  output logic call_active,
  output logic [15:0] long_call_vector,
  output logic [vih_pkg::SRC_W-1:0] service_src,
  output logic [1:0] in_service
);
  import vih_pkg::*;

  vih_core_type state_reg;
  vih_core_type state_next;

  logic [NUM_EXT-1:0] ext_pin;
  logic [NUM_EXT-1:0] ext_sense;
  logic [NUM_EXT-1:0] ext_pol;
  logic [NUM_EXT-1:0] ext_active;
  logic [NUM_EXT-1:0] ext_edge;
  logic [NUM_EXT-1:0][SRC_W-1:0] ext_src;

  logic [NUM_SRC-1:0] src_enable;
  logic [NUM_SRC-1:0] src_high;
  logic [NUM_SRC-1:0] armed;
  logic [NUM_SRC-1:0] cand_high;
  logic [NUM_SRC-1:0] cand_low;
  logic [NUM_SRC-1:0] eligible;
  logic [NUM_SRC-1:0] hw_clear_now;
  logic pick_valid;
  logic pick_high;
  logic [SRC_W-1:0] pick_src;
  logic launch;
  logic return_from_irq_seen;

  // ==========================================================================
  // External inputs
  assign ext_pin = {ext_irq1_input, ext_irq0_input};
  assign ext_sense = {ext1_sense_select, ext0_sense_select};
  assign ext_pol = {ext1_polarity, ext0_polarity};
  assign ext_src[0] = SRC_EXT0;
  assign ext_src[1] = SRC_EXT1;

  // The pins are only observed here, so whatever the crossbar routes to them is left alone.
  genvar gi;
  generate
    for (gi = 0; gi < NUM_EXT; gi++) begin : g_ext
      vih_ext_sense u_sense (
        .core_clk(core_clk),
        .rstn(rstn),
        .pin(ext_pin[gi]),
        .polarity(ext_pol[gi]),
        .active(ext_active[gi]),
        .edge_event(ext_edge[gi])
      );
    end
  endgenerate

  // ==========================================================================
  // Enable and priority mapping
  always_comb begin
    src_enable = {irq_enable_ext_reg, irq_enable_reg[BASE_FIELD_W-1:0]};
    src_high = {irq_priority_ext_reg, irq_priority_reg[BASE_FIELD_W-1:0]};
    if (irq_enable_reg[GLOBAL_EN_BIT]) begin
      armed = state_reg.flags & src_enable;
    end else begin
      armed = '0;
    end
    cand_high = armed & src_high;
    cand_low = armed & ~src_high;
    // A high routine in service blocks everything, a low one blocks all but high.
    if (state_reg.in_service[1]) begin
      eligible = '0;
    end else if (state_reg.in_service[0]) begin
      eligible = cand_high;
    end else begin
      eligible = cand_high | cand_low;
    end
  end

  // ==========================================================================
  // Arbitration: high level first, then lowest source index
  always_comb begin
    pick_valid = 1'b0;
    pick_high = 1'b0;
    pick_src = '0;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (eligible[i] && !src_high[i] && !(|(eligible & src_high))) begin
        pick_valid = 1'b1;
        pick_high = 1'b0;
        pick_src = SRC_W'(i);
      end
    end
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (eligible[i] && src_high[i]) begin
        pick_valid = 1'b1;
        pick_high = 1'b1;
        pick_src = SRC_W'(i);
      end
    end
  end

  // ==========================================================================
  // Call launch and return handling
  always_comb begin
    return_from_irq_seen = cpu_instr_done & cpu_instr_is_return_from_irq;
    // The request was sampled a cycle earlier and must still be eligible now.
    // The return itself never launches, so one more instruction always runs first.
    launch = (state_reg.state == ST_RUN) && state_reg.req_valid && cpu_instr_done
      && !cpu_instr_is_return_from_irq && eligible[state_reg.req_src];
    hw_clear_now = '0;
    if (launch) begin
      hw_clear_now[state_reg.req_src] = HW_CLEAR_MASK[state_reg.req_src];
      for (int e = 0; e < NUM_EXT; e++) begin
        if (state_reg.req_src == ext_src[e] && ext_sense[e] == SENSE_LEVEL) begin
          hw_clear_now[state_reg.req_src] = 1'b0;
        end
      end
    end
  end

  // ==========================================================================
  // Next state
  always_comb begin
    state_next = state_reg;

    // Pending flags: a set in the same cycle as a clear wins.
    for (int s = 0; s < NUM_SRC; s++) begin
      if (periph_event[s] || sw_flag_set[s]) begin
        state_next.flags[s] = 1'b1;
      end else if (sw_flag_clr[s] || hw_clear_now[s]) begin
        state_next.flags[s] = 1'b0;
      end
    end
    for (int e = 0; e < NUM_EXT; e++) begin
      if (ext_sense[e] == SENSE_LEVEL) begin
        state_next.flags[ext_src[e]] = ext_active[e];
      end else if (ext_edge[e] || sw_flag_set[ext_src[e]]) begin
        state_next.flags[ext_src[e]] = 1'b1;
      end else if (sw_flag_clr[ext_src[e]] || hw_clear_now[ext_src[e]]) begin
        state_next.flags[ext_src[e]] = 1'b0;
      end else begin
        state_next.flags[ext_src[e]] = state_reg.flags[ext_src[e]];
      end
    end

    // Detection cycle: sampled and decoded on every clock.
    state_next.req_valid = pick_valid;
    state_next.req_high = pick_high;
    state_next.req_src = pick_src;

    // Return from a routine retires the highest active marker.
    if (return_from_irq_seen) begin
      if (state_reg.in_service[1]) begin
        state_next.in_service[1] = 1'b0;
      end else begin
        state_next.in_service[0] = 1'b0;
      end
    end

    case (state_reg.state)
      ST_RUN: begin
        if (launch) begin
          state_next.state = ST_CALL;
          state_next.call_cnt = CALL_CNT_LAST;
          state_next.vector = VECTOR_BASE + {state_reg.req_src, 3'h0};
          state_next.svc_src = state_reg.req_src;
          if (state_reg.req_high) begin
            state_next.in_service[1] = 1'b1;
          end else begin
            state_next.in_service[0] = 1'b1;
          end
        end
      end
      ST_CALL: begin
        if (state_reg.call_cnt == 3'h0) begin
          state_next.state = ST_RUN;
        end else begin
          state_next.call_cnt = state_reg.call_cnt - 3'h1;
        end
      end
      default: begin
        state_next.state = ST_RUN;
      end
    endcase
  end

  // ==========================================================================
  // State register
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      state_reg.state <= ST_RUN;
      state_reg.flags <= FLAGS_RESET;
      state_reg.req_valid <= 1'b0;
      state_reg.req_high <= 1'b0;
      state_reg.req_src <= '0;
      state_reg.call_cnt <= 3'h0;
      state_reg.vector <= RESET_VECTOR;
      state_reg.svc_src <= '0;
      state_reg.in_service <= IN_SERVICE_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  // ==========================================================================
  // Outputs
  assign pending_flags = state_reg.flags;
  assign ext0_pending = state_reg.flags[SRC_EXT0];
  assign ext1_pending = state_reg.flags[SRC_EXT1];
  assign irq_request = state_reg.req_valid;
  assign irq_request_high = state_reg.req_high;
  assign irq_request_src = state_reg.req_src;
  assign call_start = launch;
  assign call_active = (state_reg.state == ST_CALL);
  assign long_call_vector = state_reg.vector;
  assign service_src = state_reg.svc_src;
  assign in_service = state_reg.in_service;

endmodule : vih_irq_handler

// ---- verif/vih_irq_monitor.sv ----
`timescale 1ns/1ns
module vih_irq_monitor (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic ext0_sense_select,
  input wire logic [7:0] irq_enable_reg,
  input wire logic [vih_pkg::NUM_SRC-1:0] periph_event,
  input wire logic [vih_pkg::NUM_SRC-1:0] sw_flag_set,
  input wire logic cpu_instr_done,
  input wire logic cpu_instr_is_return_from_irq,
  input wire logic [vih_pkg::NUM_SRC-1:0] pending_flags,
  input wire logic ext0_pending,
  input wire logic irq_request_high,
  input wire logic [vih_pkg::SRC_W-1:0] irq_request_src,
  input wire logic call_start,
  input wire logic call_active,
  input wire logic [15:0] long_call_vector,
  input wire logic [1:0] in_service
);
  import vih_pkg::*;
  // ====================
  // Checks on the call sequence.
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  a_call_len: assert property (call_start |=> call_active [*4] ##1 !call_active)
    else $error("call length wrong");
  a_vector_value: assert property (call_start |=> long_call_vector ==
    16'h0003 + {9'h000, $past(irq_request_src), 3'h0}) else $error("vector wrong");
  a_global_gate: assert property (!irq_enable_reg[7] |-> !call_start)
    else $error("call with global enable off");
  a_no_overlap: assert property (call_active |-> !call_start) else $error("call overlap");
  a_done_gate: assert property (call_start |-> cpu_instr_done) else $error("call mid instr");
  a_return_from_irq_wait: assert property (cpu_instr_done && cpu_instr_is_return_from_irq |-> !call_start)
    else $error("call in return cycle");
  a_high_final: assert property (in_service[1] |-> !call_start) else $error("high preempted");
  a_flag_set: assert property (periph_event[5] || sw_flag_set[5] |=> pending_flags[5])
    else $error("flag not set");
  a_edge_clear: assert property (call_start && irq_request_src == SRC_EXT0 &&
    !ext0_sense_select |=> !ext0_pending) else $error("edge flag kept");
  a_marker_set: assert property (call_start && irq_request_high |=> in_service[1])
    else $error("high marker not set");
  c_high_call: cover property (call_start && irq_request_high);
  c_nested: cover property (in_service == 2'h3);
  c_return: cover property (cpu_instr_done && cpu_instr_is_return_from_irq && in_service != 2'h0);
endmodule : vih_irq_monitor
bind vih_irq_handler vih_irq_monitor vih_irq_monitor_i (.*);

// ---- verif/vih_cpu_model.sv ----
`timescale 1ns/1ns
module vih_cpu_model (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic call_active,
  input wire logic return_from_irq_req,
  input wire logic slow,
  output logic instr_done,
  output logic instr_is_return_from_irq
);
  logic [1:0] cnt;
  // ====================
  // Instruction stream; no instruction completes while a call runs.
  always @(negedge core_clk) begin
    if (!rstn) begin
      cnt <= 2'h0;
      instr_done <= 1'b0;
      instr_is_return_from_irq <= 1'b0;
    end else begin
      cnt <= cnt + 2'h1;
      instr_done <= !call_active && (slow ? &cnt : cnt[0]);
      instr_is_return_from_irq <= !call_active && (slow ? &cnt : cnt[0]) && return_from_irq_req;
    end
  end
endmodule : vih_cpu_model

// ---- verif/vih_irq_handler_tb.sv ----
`timescale 1ns/1ns
module vih_irq_handler_tb;
  import vih_pkg::*;
  logic core_clk = 0, rstn = 0, pin0 = 1, pin1 = 0, s0 = 0, s1 = 0, p0 = 0, p1 = 0;
  logic [7:0] en = 8'h00, pr = 8'h00;
  logic [5:0] enx = 6'h00, prx = 6'h00;
  logic [11:0] ev = 12'h000, sset = 12'h000, sclr = 12'h000, flags;
  logic done, rti, return_from_irq_req = 0, slow = 0, e0p, e1p, req, reqh, cs, ca;
  logic [3:0] rsrc, ssrc;
  logic [15:0] vec;
  logic [1:0] insv;
  int error_cnt = 0, num_checks = 0;
  vih_irq_handler vih_irq_handler_i (.core_clk(core_clk), .rstn(rstn),
    .ext_irq0_input(pin0), .ext_irq1_input(pin1), .ext0_sense_select(s0),
    .ext1_sense_select(s1), .ext0_polarity(p0), .ext1_polarity(p1), .irq_enable_reg(en),
    .irq_enable_ext_reg(enx), .irq_priority_reg(pr), .irq_priority_ext_reg(prx),
    .periph_event(ev), .sw_flag_set(sset), .sw_flag_clr(sclr), .cpu_instr_done(done),
    .cpu_instr_is_return_from_irq(rti), .pending_flags(flags), .ext0_pending(e0p), .ext1_pending(e1p),
    .irq_request(req), .irq_request_high(reqh), .irq_request_src(rsrc), .call_start(cs),
    .call_active(ca), .long_call_vector(vec), .service_src(ssrc), .in_service(insv));
  vih_cpu_model vih_cpu_model_i (.core_clk(core_clk), .rstn(rstn), .call_active(ca),
    .return_from_irq_req(return_from_irq_req), .slow(slow), .instr_done(done), .instr_is_return_from_irq(rti));
  initial forever #2 core_clk = ~core_clk;
  // ====================
  // Shared tasks.
  task print_verdict;
    $display("checks=%0d mismatches=%0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : print_verdict
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task cyc(input int n);
    repeat (n) @(negedge core_clk);
    #1;
  endtask : cyc
  task pulse(input logic [11:0] e, input logic [11:0] s, input logic [11:0] c);
    @(negedge core_clk);
    ev = e;
    sset = s;
    sclr = c;
    cyc(1);
    ev = 12'h000;
    sset = 12'h000;
    sclr = 12'h000;
  endtask : pulse
  task exp_call(input logic [15:0] v, input logic [1:0] ins);
    int k;
    for (k = 0; k < 60 && cs !== 1'b1; k++) cyc(1);
    if (k == 60) begin
      error_cnt++;
      print_verdict();
    end
    chk(rsrc, (v - 16'h0003) >> 3);
    chk(reqh, ins[1]);
    @(posedge core_clk);
    #1;
    chk(vec, v);
    chk(insv, ins);
    chk(ssrc, (v - 16'h0003) >> 3);
    cyc(1);
  endtask : exp_call
  task return_from_irq(input logic [1:0] ins);
    int k;
    return_from_irq_req = 1;
    for (k = 0; k < 60 && !(done === 1'b1 && rti === 1'b1); k++) cyc(1);
    return_from_irq_req = 0;
    if (k == 60) begin
      error_cnt++;
      print_verdict();
    end
    @(posedge core_clk);
    #1;
    chk(insv, ins);
    cyc(1);
  endtask : return_from_irq
  // ====================
  // Tests.
  initial begin
    cyc(4);
    rstn = 1;
    cyc(1);
    chk(vec, 16'h0000);
    chk(flags, 12'h000);
    en = 8'ha0;
    pulse(12'h020, 12'h000, 12'h000);
    exp_call(16'h002b, 2'h1);
    chk(flags[5], 1'b1);
    pulse(12'h000, 12'h000, 12'h020);
    return_from_irq(2'h0);
    $display("test basic done");
    en = 8'h20;
    pulse(12'h000, 12'h020, 12'h000);
    cyc(10);
    chk(flags[5], 1'b1);
    chk(req, 1'b0);
    en = 8'ha0;
    exp_call(16'h002b, 2'h1);
    return_from_irq(2'h0);
    exp_call(16'h002b, 2'h1);
    pulse(12'h000, 12'h000, 12'h020);
    return_from_irq(2'h0);
    $display("test gating done");
    slow = 1;
    en = 8'h80;
    enx = 6'h0e;
    prx = 6'h0c;
    pulse(12'h280, 12'h000, 12'h000);
    exp_call(16'h004b, 2'h2);
    pulse(12'h000, 12'h000, 12'h200);
    return_from_irq(2'h0);
    exp_call(16'h003b, 2'h1);
    pulse(12'h100, 12'h000, 12'h000);
    exp_call(16'h0043, 2'h3);
    pulse(12'h000, 12'h000, 12'h180);
    return_from_irq(2'h1);
    return_from_irq(2'h0);
    slow = 0;
    enx = 6'h00;
    $display("test priority done");
    pin0 = 0;
    cyc(3);
    chk(e0p, 1'b1);
    en = 8'h81;
    exp_call(16'h0003, 2'h1);
    chk(e0p, 1'b0);
    pin0 = 1;
    return_from_irq(2'h0);
    en = 8'h80;
    s1 = 1;
    for (int p = 0; p < 2; p++) begin
      p1 = p[0];
      pin1 = p[0];
      cyc(3);
      chk(e1p, 1'b1);
      pin1 = !p[0];
      cyc(3);
      chk(e1p, 1'b0);
    end
    $display("test external done");
    print_verdict();
  end
endmodule : vih_irq_handler_tb
